// ### eeprom_write_control.sv
// eeprom write control: byte write, row programming, control and bank regs
`timescale 1ns/100ps
`default_nettype none
module eeprom_write_control #(
	parameter int unsigned WRITE_CYCLES = nvm_pkg::write_cycles
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic [7:0]      bus_rdata,
	output logic            bus_rd_ack,
	output logic            write_busy_flag,
	output logic            row_write_running,
	output logic            standby_cut
);
	import nvm_pkg::*;

	typedef enum logic [1:0] {
		st_idle,
		st_byte,
		st_row_wait,
		st_row_commit
	} seq_e;

	localparam cnt_t last_cnt = cnt_t'(WRITE_CYCLES - 1);

	seq_e       state, next_state;
	cnt_t       cnt, next_cnt;
	logic       permit, next_permit;
	logic       row_arm, next_row_arm;
	logic       row_start, next_row_start;
	logic       standby, next_standby;
	logic       busy, next_busy;
	logic [7:0] bank, next_bank;
	logic [3:0] row, next_row;
	logic       row_got, next_row_got;
	nvm_addr_t  b_addr, next_b_addr;
	logic [7:0] b_data, next_b_data;
	logic [2:0] idx, next_idx;

	logic       arm_set, arm_clr, lat_wr, lat_mark;
	logic       mem_we;
	nvm_addr_t  mem_wa, mem_ra;
	logic [7:0] mem_wd, mem_q;
	logic       win_hit, ee_sel, ee_page, ee_live;
	logic [7:0] lat_data [row_bytes];
	logic       lat_sel  [row_bytes];

	// address decode of the banked window
	always_comb begin
		win_hit = (bus_addr[7:6] == window_tag);
		ee_sel  = (bank == bank_page0) || (bank == bank_page1);
		ee_page = (bank == bank_page1);
		ee_live = win_hit && ee_sel && !standby;
	end

	// control register, sequencer and row capture: next values
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_permit    = permit;
		next_row_arm   = row_arm;
		next_row_start = row_start;
		next_standby   = standby;
		next_bank      = bank;
		next_row       = row;
		next_row_got   = row_got;
		next_b_addr    = b_addr;
		next_b_data    = b_data;
		next_idx       = idx;
		arm_set        = 1'b0;
		arm_clr        = 1'b0;
		lat_wr         = 1'b0;
		lat_mark       = 1'b0;
		mem_we         = 1'b0;
		mem_wa         = b_addr;
		mem_wd         = b_data;
		// bank register is write-only and always writable
		if (bus_wr && bus_addr == bank_addr) begin
			next_bank = bus_wdata;
		end
		// control register, locked while busy
		if (bus_wr && bus_addr == ctrl_addr && !busy) begin
			next_permit  = bus_wdata[bit_permit];
			next_standby = bus_wdata[bit_standby];
			next_row_arm = bus_wdata[bit_arm];
			if (bus_wdata[bit_arm] && !row_arm) begin
				arm_set = 1'b1;
			end
			if (!bus_wdata[bit_arm] && row_arm) begin
				arm_clr = 1'b1;
			end
			if (bus_wdata[bit_start] && bus_wdata[bit_permit]
					&& bus_wdata[bit_arm] && row_arm) begin
				next_row_start = 1'b1;
				next_state     = st_row_wait;
				next_cnt       = '0;
			end
		end
		// any window access between arm and start marks a latch
		if (row_arm && !row_start && win_hit && (bus_rd || bus_wr)
				&& !busy) begin
			lat_mark = 1'b1;
		end
		// eeprom write: dropped if busy, off, or permit low
		if (bus_wr && ee_live && !busy && permit) begin
			if (row_arm) begin
				lat_wr = 1'b1;
				if (!row_got) begin
					next_row     = {ee_page, bus_addr[5:3]};
					next_row_got = 1'b1;
				end
			end else begin
				next_b_addr = {ee_page, bus_addr[5:0]};
				next_b_data = bus_wdata;
				next_state  = st_byte;
				next_cnt    = '0;
			end
		end
		if (arm_clr) begin
			next_row_got = 1'b0;
		end
		unique case (state)
			st_idle: begin
			end
			st_byte: begin
				if (cnt == last_cnt) begin
					mem_we     = 1'b1;
					next_state = st_idle;
				end else begin
					next_cnt = cnt + cnt_t'(1);
				end
			end
			st_row_wait: begin
				if (cnt == last_cnt) begin
					next_state = st_row_commit;
					next_idx   = '0;
				end else begin
					next_cnt = cnt + cnt_t'(1);
				end
			end
			st_row_commit: begin
				mem_we = lat_sel[idx];
				mem_wa = {row, idx};
				mem_wd = lat_data[idx];
				if (idx == 3'd7) begin
					next_state     = st_idle;
					next_row_arm   = 1'b0;
					next_row_start = 1'b0;
					next_row_got   = 1'b0;
				end else begin
					next_idx = idx + 3'd1;
				end
			end
		endcase
		next_busy = (next_state != st_idle);
	end

	// control register, sequencer and row capture: registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state     <= st_idle;
			cnt       <= '0;
			permit    <= ctrl_reset[bit_permit];
			row_arm   <= ctrl_reset[bit_arm];
			row_start <= ctrl_reset[bit_start];
			standby   <= ctrl_reset[bit_standby];
			busy      <= ctrl_reset[bit_busy];
			bank      <= 8'h00;
			row       <= 4'h0;
			row_got   <= 1'b0;
			b_addr    <= '0;
			b_data    <= 8'h00;
			idx       <= 3'h0;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			permit    <= next_permit;
			row_arm   <= next_row_arm;
			row_start <= next_row_start;
			standby   <= next_standby;
			busy      <= next_busy;
			bank      <= next_bank;
			row       <= next_row;
			row_got   <= next_row_got;
			b_addr    <= next_b_addr;
			b_data    <= next_b_data;
			idx       <= next_idx;
		end
	end

	// eight volatile row latches, each with a select mark
	for (genvar i = 0; i < row_bytes; i++) begin : g_latch
		logic [7:0] next_data;
		logic       next_sel;
		logic       hit;

		always_comb begin
			hit       = (bus_addr[2:0] == 3'(i));
			next_data = lat_data[i];
			next_sel  = lat_sel[i];
			if (arm_set) begin
				next_data = latch_blank;
				next_sel  = 1'b0;
			end else if (lat_wr && hit) begin
				next_data = bus_wdata;
				next_sel  = 1'b1;
			end else if (lat_mark && hit) begin
				next_sel  = 1'b1;
			end
		end

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				lat_data[i] <= latch_blank;
				lat_sel[i]  <= 1'b0;
			end else begin
				lat_data[i] <= next_data;
				lat_sel[i]  <= next_sel;
			end
		end
	end

	// read address: whole page until a row is captured, then that row only
	always_comb begin
		if (row_arm && row_got) begin
			mem_ra = {row, bus_addr[2:0]};
		end else begin
			mem_ra = {ee_page, bus_addr[5:0]};
		end
	end

	nvm_array u_array (
		.clk     (clk),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_addr (mem_ra),
		.rd_data (mem_q)
	);

	// read pipeline: stage one picks the source, stage two drives the bus
	read_kind_e kind, next_kind;
	logic       rd_p1, next_rd_p1;
	logic [7:0] snap, next_snap;
	logic [7:0] next_rdata;
	logic       next_ack;

	always_comb begin
		next_rd_p1 = bus_rd;
		next_kind  = read_zero;
		next_snap  = {1'b0, standby, 2'b00, row_start, row_arm, busy, permit};
		if (bus_rd && ee_live && !busy) begin
			next_kind = read_mem;
		end else if (bus_rd && bus_addr == ctrl_addr) begin
			next_kind = read_ctrl;
		end
		next_ack   = rd_p1;
		next_rdata = 8'h00;
		if (rd_p1 && kind == read_mem) begin
			next_rdata = mem_q;
		end else if (rd_p1 && kind == read_ctrl) begin
			next_rdata = snap;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_p1      <= 1'b0;
			kind       <= read_zero;
			snap       <= ctrl_reset;
			bus_rdata  <= 8'h00;
			bus_rd_ack <= 1'b0;
		end else begin
			rd_p1      <= next_rd_p1;
			kind       <= next_kind;
			snap       <= next_snap;
			bus_rdata  <= next_rdata;
			bus_rd_ack <= next_ack;
		end
	end

	// status outputs
	assign write_busy_flag   = busy;
	assign row_write_running = row_start;
	assign standby_cut       = standby;
endmodule : eeprom_write_control
`default_nettype wire

// ### nvm_pkg.sv
// shared constants for the eeprom write control block
package nvm_pkg;
	// data space addresses
	localparam logic [7:0] ctrl_addr     = 8'hea;
	localparam logic [7:0] bank_addr     = 8'he8;
	localparam logic [1:0] window_tag    = 2'h0;
	// bank select values for the two eeprom pages
	localparam logic [7:0] bank_page0    = 8'h01;
	localparam logic [7:0] bank_page1    = 8'h02;
	// control register field positions
	localparam int         bit_permit    = 0;
	localparam int         bit_busy      = 1;
	localparam int         bit_arm       = 2;
	localparam int         bit_start     = 3;
	localparam int         bit_standby   = 6;
	localparam logic [7:0] ctrl_reset    = 8'h00;
	// value of a cleared row latch
	localparam logic [7:0] latch_blank   = 8'hff;
	localparam int         row_bytes     = 8;
	// self-timed write
	localparam int         clk_mhz       = 25;
	localparam int         write_time_us = 5000;
	localparam int         write_max_us  = 10000;
	localparam int         write_cycles  = write_time_us * clk_mhz;
	typedef logic [17:0] cnt_t;
	typedef logic [6:0]  nvm_addr_t;
	typedef enum logic [1:0] {
		read_zero,
		read_mem,
		read_ctrl
	} read_kind_e;
endpackage : nvm_pkg

// ### nvm_array.sv
// 128 x 8 nonvolatile cell array with registered read data
`timescale 1ns/100ps
`default_nettype none
module nvm_array (
	input  wire logic             clk,
	input  wire logic             wr_en,
	input  wire nvm_pkg::nvm_addr_t wr_addr,
	input  wire logic [7:0]       wr_data,
	input  wire nvm_pkg::nvm_addr_t rd_addr,
	output logic [7:0]            rd_data
);
	import nvm_pkg::*;

	logic [7:0] cells [128];

	// one write port, read data registered every cycle
	always_ff @(posedge clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
		rd_data <= cells[rd_addr];
	end
endmodule : nvm_array
`default_nettype wire

// ### ewc_core.sv
// core model that drives the register bus of the eeprom control block
`timescale 1ns/100ps
`default_nettype none
module ewc_core (
	input  wire logic       clk,
	input  wire logic       rd_ack,
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// one write: strobe for one cycle, then scramble the released lines
	task wr_op(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
		@(negedge clk);
	endtask : wr_op
	// one read: strobe, then wait a bounded time for the answer
	// the wait ends on the answer pulse, not on the data, since an unwritten
	// cell reads back unknown
	task rd_op(input logic [7:0] a, output logic [7:0] d);
		logic got;
		got = 1'b0;
		d = 8'hxx;
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		addr = ~a;
		for (int i = 0; i < 4 && !got; i++) begin
			@(negedge clk);
			if (rd_ack === 1'b1) begin
				d = rdata;
				got = 1'b1;
			end
		end
	endtask : rd_op
endmodule : ewc_core
`default_nettype wire

// ### eeprom_write_control_monitor.sv
// assertions on the ports of the eeprom write control block
`timescale 1ns/100ps
`default_nettype none
module eeprom_write_control_monitor #(
	parameter int unsigned WRITE_CYCLES = nvm_pkg::write_cycles
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic       bus_rd_ack,
	input wire logic       write_busy_flag,
	input wire logic       row_write_running,
	input wire logic       standby_cut
);
	import nvm_pkg::*;

	logic [17:0] cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// counts the edges at which busy was seen high
	always_ff @(posedge clk) cnt <= write_busy_flag ? cnt + 18'h1 : 18'h0;
	a_ack_two: assert property (bus_rd |-> ##2 bus_rd_ack)
		else $error("read answer not two cycles after strobe");
	a_busy_read: assert property (bus_rd && write_busy_flag &&
		bus_addr < 8'h40 |-> ##2 bus_rdata == 8'h00)
		else $error("read while busy was not refused");
	a_busy_cause: assert property ($rose(write_busy_flag) |-> $past(bus_wr))
		else $error("busy rose without a write");
	a_busy_span: assert property ($fell(write_busy_flag) |-> cnt ==
		($past(row_write_running) ? WRITE_CYCLES + 8 : WRITE_CYCLES))
		else $error("busy interval has wrong length");
	a_ctrl_locked: assert property (bus_wr && write_busy_flag &&
		bus_addr == ctrl_addr |=> $stable(standby_cut))
		else $error("control changed while busy");
	a_standby_set: assert property (bus_wr && !write_busy_flag &&
		bus_addr == ctrl_addr |=> standby_cut == $past(bus_wdata[bit_standby]))
		else $error("standby bit not taken from write");
	a_start_cause: assert property ($rose(row_write_running) |->
		$past(bus_wr) && $past(bus_addr) == ctrl_addr)
		else $error("row start without control write");
	a_start_busy: assert property (row_write_running |-> write_busy_flag)
		else $error("row running without busy");
	a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
		!write_busy_flag && !row_write_running && !standby_cut)
		else $error("outputs not cleared by reset");
	c_byte: cover property ($rose(write_busy_flag) && !row_write_running);
	c_row: cover property ($rose(row_write_running));
	c_standby: cover property ($rose(standby_cut));
endmodule : eeprom_write_control_monitor
bind eeprom_write_control eeprom_write_control_monitor #(
	.WRITE_CYCLES(WRITE_CYCLES)
) u_mon (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .bus_rd_ack(bus_rd_ack),
	.write_busy_flag(write_busy_flag),
	.row_write_running(row_write_running), .standby_cut(standby_cut));
`default_nettype wire

// ### tb_eeprom_write_control.sv
// self-checking testbench for the eeprom write control block
`timescale 1ns/100ps
`default_nettype none
module tb_eeprom_write_control;
	import nvm_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  bus_addr, bus_wdata, bus_rdata, d;
	logic        bus_wr, bus_rd, bus_rd_ack, write_busy_flag;
	logic        row_write_running, standby_cut;
	int          err_count = 0;
	int          cmp_count = 0;
	logic [23:0] rows [3] = '{24'h0105a5, 24'h023f5a, 24'h010000};
	// 25 mhz clock
	always #20 clk = ~clk;
	ewc_core u_core (.clk(clk), .rd_ack(bus_rd_ack), .rdata(bus_rdata),
		.addr(bus_addr), .wdata(bus_wdata), .wr(bus_wr), .rd(bus_rd));
	eeprom_write_control #(.WRITE_CYCLES(8)) u_dut (.clk(clk),
		.sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.bus_rd_ack(bus_rd_ack), .write_busy_flag(write_busy_flag),
		.row_write_running(row_write_running), .standby_cut(standby_cut));
	task give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task check(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// read one location and compare
	task rchk(input logic [7:0] a, input logic [7:0] e);
		u_core.rd_op(a, d);
		check("read", e, d);
	endtask : rchk
	// bounded poll of the busy flag
	task wait_idle;
		for (int i = 0; i < 40 && write_busy_flag !== 1'b0; i++) @(negedge clk);
		if (write_busy_flag !== 1'b0) begin
			$display("BAD busy expected 0 seen %b", write_busy_flag);
			err_count++;
			give_verdict();
		end
	endtask : wait_idle
	initial begin
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		rchk(ctrl_addr, ctrl_reset);
		foreach (rows[i]) begin
			u_core.wr_op(bank_addr, rows[i][23:16]);
			u_core.wr_op(ctrl_addr, 8'h01);
			u_core.wr_op(rows[i][15:8], rows[i][7:0]);
			rchk(ctrl_addr, 8'h03);
			wait_idle();
			rchk(rows[i][15:8], rows[i][7:0]);
		end
		// busy: window and control are closed, the write still lands
		u_core.wr_op(8'h10, 8'h77);
		rchk(8'h05, 8'h00);
		u_core.wr_op(8'h05, 8'h99);
		u_core.wr_op(ctrl_addr, 8'h41);
		check("standby", 8'h00, {7'h0, standby_cut});
		wait_idle();
		rchk(8'h10, 8'h77);
		rchk(8'h05, 8'ha5);
		// write with permit low
		u_core.wr_op(ctrl_addr, 8'h00);
		u_core.wr_op(8'h05, 8'h3c);
		check("busy", 8'h00, {7'h0, write_busy_flag});
		rchk(8'h05, 8'ha5);
		// start without arm
		u_core.wr_op(ctrl_addr, 8'h09);
		check("start", 8'h00, {7'h0, row_write_running});
		rchk(ctrl_addr, 8'h01);
		// row: two writes, one read mark, then start
		u_core.wr_op(ctrl_addr, 8'h05);
		u_core.wr_op(8'h18, 8'h11);
		u_core.wr_op(8'h1a, 8'h22);
		u_core.rd_op(8'h1b, d);
		u_core.wr_op(ctrl_addr, 8'h0d);
		check("start", 8'h01, {7'h0, row_write_running});
		wait_idle();
		rchk(8'h18, 8'h11);
		rchk(8'h1a, 8'h22);
		rchk(8'h1b, 8'hff);
		rchk(ctrl_addr, 8'h01);
		// captured row hides the others; disarm leaves the array alone
		u_core.wr_op(ctrl_addr, 8'h05);
		u_core.wr_op(8'h18, 8'h44);
		rchk(8'h0a, 8'h22);
		u_core.wr_op(ctrl_addr, 8'h01);
		check("busy", 8'h00, {7'h0, write_busy_flag});
		rchk(8'h18, 8'h11);
		// standby: window accesses are dropped
		u_core.wr_op(ctrl_addr, 8'h41);
		check("standby", 8'h01, {7'h0, standby_cut});
		u_core.wr_op(8'h05, 8'h3c);
		check("busy", 8'h00, {7'h0, write_busy_flag});
		rchk(8'h05, 8'h00);
		u_core.wr_op(ctrl_addr, 8'h01);
		check("standby", 8'h00, {7'h0, standby_cut});
		rchk(8'h05, 8'ha5);
		// a bank value that maps no eeprom page
		u_core.wr_op(bank_addr, 8'h04);
		u_core.wr_op(8'h05, 8'h3c);
		check("busy", 8'h00, {7'h0, write_busy_flag});
		rchk(8'h05, 8'h00);
		u_core.wr_op(bank_addr, bank_page0);
		rchk(8'h05, 8'ha5);
		// reset in mid-run clears control and bank registers
		u_core.wr_op(ctrl_addr, 8'h45);
		check("standby", 8'h01, {7'h0, standby_cut});
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		check("standby", 8'h00, {7'h0, standby_cut});
		rchk(ctrl_addr, ctrl_reset);
		rchk(8'h05, 8'h00);
		give_verdict();
	end
endmodule : tb_eeprom_write_control
`default_nettype wire
